/* rtl/dlac_pkg.sv */
// constants for the deserializer link audio configuration register group
package dlac_pkg;
	localparam logic [7:0] OFS_TALLY = 8'h25;
	localparam logic [7:0] OFS_HIGH = 8'h26;
	localparam logic [7:0] OFS_LOW = 8'h27;
	localparam logic [7:0] OFS_PATH = 8'h28;
	localparam logic [7:0] OFS_AUDIO = 8'h2b;
	localparam logic [7:0] OFS_MODE = 8'h34;
	localparam logic [7:0] RST_TALLY = 8'h00;
	localparam logic [7:0] RST_HIGH = 8'h83;
	localparam logic [7:0] RST_LOW = 8'h84;
	localparam logic [7:0] RST_PATH = 8'h00;
	localparam logic [7:0] RST_AUDIO = 8'h00;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [7:0] PATH_WMASK = 8'hbf;
	localparam logic [7:0] PATH_REMOTE_MASK = 8'h3f;
	localparam logic [7:0] AUDIO_WMASK = 8'h01;
	localparam int B_KEEP = 7;
	localparam int B_NOVIDEO = 5;
	localparam int B_DUAL = 4;
	localparam int B_ALT = 3;
	localparam int B_NOI2S = 2;
	localparam int B_SYNC = 1;
	localparam int B_SURR = 0;
	localparam int B_OVR = 3;
	localparam int B_UND = 2;
	localparam int B_ERRCLR = 1;
	localparam int B_RISE = 0;
	localparam int B_MODE = 3;
	localparam int UNIT_NS = 50;
	localparam int CLK_NS = 20;
	localparam int UNIT_CYC = (UNIT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] MODE_AUTO = 2'h0;
	localparam logic [1:0] MODE_DUAL = 2'h1;
	localparam logic [1:0] MODE_PRI = 2'h2;
	localparam logic [1:0] MODE_SEC = 2'h3;
endpackage : dlac_pkg

/* rtl/dlac_regs.sv */
// register group: self-test tally, master clock widths, path config, audio control
//
// Contract
// R1: read-only self-test error tally at 0x25
// R2: master clock high for high-width units
// R3: high width resets to 0x83
// R4: master clock low width, resets 0x84
// R5: slave data setup uses low width
// R6: bit 7 blocks remote config updates
// R7: bit 5 remote video-disabled status
// R8: bit 4 single/dual link from remote
// R9: bit 3 alternate audio on gpio pins
// R10: bit 1 sync bits in stream
// R11: bit 0 surround audio enable
// R12: overrun bit 3, underrun bit 2
// R13: write 1 bit 1 clears fifo errors
// R14: bit 0 selects audio strobe edge
// R15: link input mode field selection
// R16: reserved bits read zero
module dlac_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic tally_inc,
	input wire logic tally_clr,
	input wire logic remote_valid,
	input wire logic [7:0] remote_cfg,
	input wire logic fifo_overrun,
	input wire logic fifo_underrun,
	input wire logic master_run,
	output logic master_scl,
	input wire logic slave_hold,
	output logic slave_release,
	input wire logic rx_dual_detect,
	output logic use_dual,
	output logic use_secondary,
	output logic video_disabled,
	output logic alt_audio_en,
	output logic audio_disabled,
	output logic sync_bits_in_stream,
	output logic surround_en,
	output logic strobe_rising
);
	logic [7:0] tally_reg;
	logic [7:0] high_reg;
	logic [7:0] low_reg;
	logic [7:0] path_reg;
	logic [7:0] path_next;
	logic [1:0] mode_reg;
	logic ovr_reg;
	logic und_reg;
	logic rise_reg;
	logic [7:0] unit_reg;
	logic [7:0] width_reg;
	logic phase_reg;
	logic [7:0] setup_reg;
	logic settle_reg;
	logic [7:0] rdata_reg;

	typedef enum logic [1:0] {
		SL_IDLE = 2'b01,
		SL_SETUP = 2'b10
	} dlac_slave_t;
	dlac_slave_t slave_reg;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	wire wr_high = reg_wr && hit(reg_addr, dlac_pkg::OFS_HIGH);
	wire wr_low = reg_wr && hit(reg_addr, dlac_pkg::OFS_LOW);
	wire wr_path = reg_wr && hit(reg_addr, dlac_pkg::OFS_PATH);
	wire wr_audio = reg_wr && hit(reg_addr, dlac_pkg::OFS_AUDIO);
	wire wr_mode = reg_wr && hit(reg_addr, dlac_pkg::OFS_MODE);
	wire err_clr = wr_audio && reg_wdata[dlac_pkg::B_ERRCLR]; // R13
	wire keep_local_path_cfg = path_reg[dlac_pkg::B_KEEP];
	wire take_remote = remote_valid && !keep_local_path_cfg; // R6
	wire unit_tick = unit_reg == 8'(dlac_pkg::UNIT_CYC - 1);
	wire [7:0] cur_width = phase_reg ? high_reg : low_reg; // R2 R4
	wire width_done = unit_tick && (width_reg + 8'h01 >= cur_width);
	wire setup_done = unit_tick && (setup_reg + 8'h01 >= low_reg);
	wire [7:0] audio_view = {4'h0, ovr_reg, und_reg, 1'b0, rise_reg}; // R12 R16
	wire [7:0] mode_view = 8'(mode_reg) << dlac_pkg::B_MODE;

	always_comb begin
		path_next = path_reg;
		if (take_remote)
			path_next = (path_reg & ~dlac_pkg::PATH_REMOTE_MASK)
				| (remote_cfg & dlac_pkg::PATH_REMOTE_MASK); // R7 R8
		if (wr_path)
			path_next = reg_wdata & dlac_pkg::PATH_WMASK; // R16
	end

	wire [7:0] rd_mux =
		hit(reg_addr, dlac_pkg::OFS_TALLY) ? tally_reg : // R1
		hit(reg_addr, dlac_pkg::OFS_HIGH) ? high_reg :
		hit(reg_addr, dlac_pkg::OFS_LOW) ? low_reg :
		hit(reg_addr, dlac_pkg::OFS_PATH) ? path_reg :
		hit(reg_addr, dlac_pkg::OFS_AUDIO) ? audio_view :
		hit(reg_addr, dlac_pkg::OFS_MODE) ? mode_view : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			tally_reg <= dlac_pkg::RST_TALLY; // R1
			high_reg <= dlac_pkg::RST_HIGH; // R3
			low_reg <= dlac_pkg::RST_LOW; // R4
			path_reg <= dlac_pkg::RST_PATH;
			mode_reg <= dlac_pkg::RST_MODE;
			rise_reg <= dlac_pkg::RST_AUDIO[dlac_pkg::B_RISE];
			rdata_reg <= 8'h00;
		end else if (ce) begin
			if (tally_clr)
				tally_reg <= dlac_pkg::RST_TALLY;
			else if (tally_inc && tally_reg != 8'hff)
				tally_reg <= tally_reg + 8'h01; // R1
			if (wr_high)
				high_reg <= reg_wdata;
			if (wr_low)
				low_reg <= reg_wdata;
			path_reg <= path_next;
			if (wr_mode)
				mode_reg <= reg_wdata[dlac_pkg::B_MODE +: 2]; // R15
			if (wr_audio)
				rise_reg <= reg_wdata[dlac_pkg::B_RISE]; // R14
			if (reg_rd)
				rdata_reg <= rd_mux;
		end
	end

	// sticky fifo errors, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			ovr_reg <= 1'b0;
			und_reg <= 1'b0;
		end else if (ce) begin
			ovr_reg <= fifo_overrun | (ovr_reg & ~err_clr); // R12 R13
			und_reg <= fifo_underrun | (und_reg & ~err_clr); // R12 R13
		end
	end

	// master clock generator in 3-clock (60 ns) units
	always_ff @(posedge clk) begin
		if (rst) begin
			unit_reg <= 8'h00;
			width_reg <= 8'h00;
			phase_reg <= 1'b1;
		end else if (ce) begin
			unit_reg <= (unit_tick || (!master_run && slave_reg == SL_IDLE)) ? 8'h00
				: unit_reg + 8'h01;
			if (!master_run) begin
				width_reg <= 8'h00;
				phase_reg <= 1'b1;
			end else if (width_done) begin
				width_reg <= 8'h00;
				phase_reg <= ~phase_reg; // R2 R4
			end else if (unit_tick) begin
				width_reg <= width_reg + 8'h01;
			end
		end
	end

	// slave clock stretch: data setup before release
	always_ff @(posedge clk) begin
		if (rst) begin
			slave_reg <= SL_IDLE;
			setup_reg <= 8'h00;
			settle_reg <= 1'b0;
		end else if (ce) begin
			settle_reg <= 1'b0;
			unique case (slave_reg)
				SL_IDLE: begin
					setup_reg <= 8'h00;
					if (slave_hold)
						slave_reg <= SL_SETUP;
				end
				SL_SETUP: begin
					if (setup_done) begin
						slave_reg <= SL_IDLE; // R5
						settle_reg <= 1'b1;
					end else if (unit_tick) begin
						setup_reg <= setup_reg + 8'h01;
					end
				end
			endcase
		end
	end

	assign reg_rdata = rdata_reg;
	assign master_scl = phase_reg;
	assign slave_release = settle_reg; // R5
	assign video_disabled = path_reg[dlac_pkg::B_NOVIDEO]; // R7
	assign alt_audio_en = path_reg[dlac_pkg::B_ALT]; // R9
	assign audio_disabled = path_reg[dlac_pkg::B_NOI2S];
	assign sync_bits_in_stream = path_reg[dlac_pkg::B_SYNC]; // R10
	assign surround_en = path_reg[dlac_pkg::B_SURR]; // R11
	assign strobe_rising = rise_reg; // R14
	assign use_dual = (mode_reg == dlac_pkg::MODE_DUAL)
		|| (mode_reg == dlac_pkg::MODE_AUTO && path_reg[dlac_pkg::B_DUAL]); // R8 R15
	assign use_secondary = mode_reg == dlac_pkg::MODE_SEC; // R15

	// multi-step timing windows for the checks below
	sequence seq_high_start;
		ce && master_run && !reg_wr && $rose(phase_reg);
	endsequence : seq_high_start
	sequence seq_low_start;
		ce && master_run && !reg_wr && $fell(phase_reg);
	endsequence : seq_low_start
	sequence seq_run_two;
		(ce && master_run && !reg_wr)[*2];
	endsequence : seq_run_two
	sequence seq_run_three;
		(ce && master_run && !reg_wr)[*3];
	endsequence : seq_run_three
	sequence seq_hold_start;
		ce && !master_run && !reg_wr && slave_reg == SL_IDLE && slave_hold;
	endsequence : seq_hold_start
	sequence seq_quiet_six;
		(ce && !reg_wr)[*6];
	endsequence : seq_quiet_six

	AST_KEEP: assert property (@(posedge clk) disable iff (rst) // R6
		ce && keep_local_path_cfg && !wr_path |=> $stable(path_reg))
		else $error("path config changed while kept local");
	AST_REMOTE: assert property (@(posedge clk) disable iff (rst) // R7
		ce && take_remote && !wr_path |=> video_disabled == $past(remote_cfg[dlac_pkg::B_NOVIDEO]))
		else $error("remote video bit not taken");
	AST_OVR: assert property (@(posedge clk) disable iff (rst) // R12
		ce && fifo_overrun |=> ovr_reg)
		else $error("overrun not recorded");
	AST_CLR: assert property (@(posedge clk) disable iff (rst) // R13
		ce && err_clr && !fifo_overrun && !fifo_underrun |=> !ovr_reg && !und_reg)
		else $error("fifo errors not cleared");
	AST_EDGE: assert property (@(posedge clk) disable iff (rst) // R14
		ce && wr_audio |=> strobe_rising == $past(reg_wdata[dlac_pkg::B_RISE]))
		else $error("strobe edge not written");
	AST_RSV: assert property (@(posedge clk) disable iff (rst) // R16
		audio_view[7:4] == 4'h0 && path_reg[6] == 1'b0)
		else $error("reserved bits not zero");
	AST_MODE: assert property (@(posedge clk) disable iff (rst) // R15
		mode_reg == dlac_pkg::MODE_DUAL |-> use_dual && !use_secondary)
		else $error("forced dual mode not applied");
	AST_TALLY: assert property (@(posedge clk) disable iff (rst) // R1
		ce && reg_wr && reg_addr == dlac_pkg::OFS_TALLY && !tally_inc && !tally_clr
			|=> $stable(tally_reg))
		else $error("tally changed by write");
	AST_HIGH: assert property (@(posedge clk) disable iff (rst) // R2
		seq_high_start ##1 seq_run_two |-> phase_reg)
		else $error("master clock high too short");
	AST_LOWRST: assert property (@(posedge clk) // R3
		rst |=> high_reg == dlac_pkg::RST_HIGH && low_reg == dlac_pkg::RST_LOW)
		else $error("width reset values wrong");
	AST_LOW: assert property (@(posedge clk) disable iff (rst) // R4
		seq_low_start ##1 seq_run_two |-> !phase_reg)
		else $error("master clock low too short");
	AST_LOWEND: assert property (@(posedge clk) disable iff (rst) // R4
		seq_low_start ##0 (low_reg == 8'h01) ##1 seq_run_three |-> phase_reg)
		else $error("master clock low too long");
	AST_SCLIDLE: assert property (@(posedge clk) disable iff (rst) // R2
		ce && !master_run |=> master_scl)
		else $error("master clock not high when idle");
	AST_HIGHWR: assert property (@(posedge clk) disable iff (rst) // R2
		ce && wr_high |=> high_reg == $past(reg_wdata))
		else $error("high width not written");
	AST_SETUP: assert property (@(posedge clk) disable iff (rst) // R5
		seq_hold_start |=> (!slave_release)[*3])
		else $error("slave released before setup");
	AST_RELEASE: assert property (@(posedge clk) disable iff (rst) // R5
		seq_hold_start ##0 (low_reg == 8'h02) ##1 seq_quiet_six |=> slave_release)
		else $error("slave not released after setup");
	AST_TALLYSAT: assert property (@(posedge clk) disable iff (rst) // R1
		ce && tally_inc && !tally_clr && tally_reg == 8'hff |=> tally_reg == 8'hff)
		else $error("tally wrapped");
	AST_TALLYCLR: assert property (@(posedge clk) disable iff (rst) // R1
		ce && tally_clr |=> tally_reg == dlac_pkg::RST_TALLY)
		else $error("tally not cleared");
	AST_RDATA: assert property (@(posedge clk) disable iff (rst) // R1
		ce && reg_rd && reg_addr == dlac_pkg::OFS_TALLY |=> reg_rdata == $past(tally_reg))
		else $error("tally read wrong");
	AST_RSTPATH: assert property (@(posedge clk) // R1
		rst |=> tally_reg == dlac_pkg::RST_TALLY && path_reg == dlac_pkg::RST_PATH)
		else $error("tally or path reset value wrong");
	AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(tally_reg) && $stable(path_reg) && $stable(phase_reg)
			&& $stable(slave_reg) && $stable(ovr_reg) && $stable(und_reg))
		else $error("state changed while clock enable low");
	AST_UND: assert property (@(posedge clk) disable iff (rst) // R12
		ce && fifo_underrun |=> und_reg)
		else $error("underrun not recorded");
	AST_SETWIN: assert property (@(posedge clk) disable iff (rst) // R13
		ce && err_clr && fifo_overrun |=> ovr_reg)
		else $error("clear beat a new overrun");
	AST_PATHWR: assert property (@(posedge clk) disable iff (rst) // R16
		ce && wr_path |=> path_reg == ($past(reg_wdata) & dlac_pkg::PATH_WMASK))
		else $error("path write not masked");
	AST_AUDRD: assert property (@(posedge clk) disable iff (rst) // R16
		ce && reg_rd && reg_addr == dlac_pkg::OFS_AUDIO |=> reg_rdata[7:4] == 4'h0)
		else $error("audio reserved bits read nonzero");
	AST_SEC: assert property (@(posedge clk) disable iff (rst) // R15
		mode_reg == dlac_pkg::MODE_SEC |-> use_secondary && !use_dual)
		else $error("forced secondary mode not applied");
	AST_AUTO: assert property (@(posedge clk) disable iff (rst) // R8
		mode_reg == dlac_pkg::MODE_AUTO |-> use_dual == path_reg[dlac_pkg::B_DUAL])
		else $error("auto mode ignores remote link bit");
endmodule : dlac_regs

/* test/dlac_remote.sv */
// far-side model: remote serializer config frames and audio fifo events
module dlac_remote (
	input wire logic clk,
	output logic remote_valid,
	output logic [7:0] remote_cfg,
	output logic fifo_overrun,
	output logic fifo_underrun
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		remote_valid = 1'b0;
		remote_cfg = 8'h00;
		fifo_overrun = 1'b0;
		fifo_underrun = 1'b0;
	end
	// one config frame, then the bus shows the inverse
	task automatic send(input logic [7:0] cfg);
		@(negedge clk);
		remote_valid = 1'b1;
		remote_cfg = cfg;
		@(negedge clk);
		remote_valid = 1'b0;
		remote_cfg = ~cfg;
	endtask : send
	task automatic fifo_event(input logic ovr);
		@(negedge clk);
		fifo_overrun = ovr;
		fifo_underrun = ~ovr;
		@(negedge clk);
		fifo_overrun = 1'b0;
		fifo_underrun = 1'b0;
	endtask : fifo_event
endmodule : dlac_remote

/* test/testbench.sv */
// self-checking bench for the register group
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic tally_inc = 1'b0;
	logic tally_clr = 1'b0;
	logic master_run = 1'b0;
	logic slave_hold = 1'b0;
	logic rx_dual_detect = 1'b0;
	logic [7:0] reg_rdata, remote_cfg;
	logic remote_valid, fifo_overrun, fifo_underrun, master_scl, slave_release;
	logic use_dual, use_secondary, video_disabled, alt_audio_en, audio_disabled;
	logic sync_bits_in_stream, surround_en, strobe_rising;
	logic [1:0] mode_exp [4] = '{2'h2, 2'h2, 2'h0, 2'h1};
	int error_cnt = 0;
	int num_checks = 0;
	int n;
	always #10 clk = ~clk;
	dlac_regs dlac_regs_inst (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.tally_inc(tally_inc), .tally_clr(tally_clr), .remote_valid(remote_valid),
		.remote_cfg(remote_cfg), .fifo_overrun(fifo_overrun), .fifo_underrun(fifo_underrun),
		.master_run(master_run), .master_scl(master_scl), .slave_hold(slave_hold),
		.slave_release(slave_release), .rx_dual_detect(rx_dual_detect), .use_dual(use_dual),
		.use_secondary(use_secondary), .video_disabled(video_disabled),
		.alt_audio_en(alt_audio_en), .audio_disabled(audio_disabled),
		.sync_bits_in_stream(sync_bits_in_stream), .surround_en(surround_en),
		.strobe_rising(strobe_rising));
	dlac_remote dlac_remote_inst (.clk(clk), .remote_valid(remote_valid),
		.remote_cfg(remote_cfg), .fifo_overrun(fifo_overrun), .fifo_underrun(fifo_underrun));
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk("reg_rdata", reg_rdata, exp);
	endtask : rd
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	// bounded wait for a level on the master clock
	task automatic wait_scl(input logic lvl);
		int i;
		for (i = 0; i < 3000 && master_scl !== lvl; i++) @(negedge clk);
		if (i == 3000) begin
			error_cnt++;
			wrap_up();
		end
	endtask : wait_scl
	task automatic phase(input logic lvl, input int exp);
		int k;
		wait_scl(~lvl);
		wait_scl(lvl);
		for (k = 0; k < 3000 && master_scl === lvl; k++) @(negedge clk);
		chk("scl phase", k, exp);
	endtask : phase
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		rd(dlac_pkg::OFS_TALLY, 8'h00);
		rd(dlac_pkg::OFS_HIGH, 8'h83);
		rd(dlac_pkg::OFS_LOW, 8'h84);
		rd(dlac_pkg::OFS_AUDIO, 8'h00);
		rd(8'h30, 8'h00);
		wr(dlac_pkg::OFS_TALLY, 8'h5a);
		repeat (3) pulse(tally_inc);
		rd(dlac_pkg::OFS_TALLY, 8'h03);
		pulse(tally_clr);
		rd(dlac_pkg::OFS_TALLY, 8'h00);
		ce = 1'b0;
		pulse(tally_inc);
		ce = 1'b1;
		rd(dlac_pkg::OFS_TALLY, 8'h00);
		tally_inc = 1'b1;
		repeat (260) @(negedge clk);
		tally_inc = 1'b0;
		rd(dlac_pkg::OFS_TALLY, 8'hff);
		dlac_remote_inst.send(8'hff);
		rd(dlac_pkg::OFS_PATH, 8'h3f);
		dlac_remote_inst.send(8'h29);
		rd(dlac_pkg::OFS_PATH, 8'h29);
		chk("outs", {video_disabled, alt_audio_en, sync_bits_in_stream, surround_en}, 4'hd);
		wr(dlac_pkg::OFS_PATH, 8'hff);
		rd(dlac_pkg::OFS_PATH, 8'hbf);
		wr(dlac_pkg::OFS_PATH, 8'h80);
		dlac_remote_inst.send(8'h15);
		rd(dlac_pkg::OFS_PATH, 8'h80);
		wr(dlac_pkg::OFS_PATH, 8'h00);
		dlac_remote_inst.send(8'h15);
		rd(dlac_pkg::OFS_PATH, 8'h15);
		chk("audio_disabled", audio_disabled, 1'b1);
		rx_dual_detect = 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(dlac_pkg::OFS_MODE, 8'(m << 3));
			chk("link mode", {use_dual, use_secondary}, mode_exp[m]);
		end
		dlac_remote_inst.fifo_event(1'b1);
		rd(dlac_pkg::OFS_AUDIO, 8'h08);
		dlac_remote_inst.fifo_event(1'b0);
		rd(dlac_pkg::OFS_AUDIO, 8'h0c);
		wr(dlac_pkg::OFS_AUDIO, 8'h02);
		rd(dlac_pkg::OFS_AUDIO, 8'h00);
		wr(dlac_pkg::OFS_AUDIO, 8'hff);
		rd(dlac_pkg::OFS_AUDIO, 8'h01);
		chk("strobe_rising", strobe_rising, 1'b1);
		fork
			wr(dlac_pkg::OFS_AUDIO, 8'h02);
			dlac_remote_inst.fifo_event(1'b1);
		join
		rd(dlac_pkg::OFS_AUDIO, 8'h08);
		wr(dlac_pkg::OFS_HIGH, 8'h02);
		wr(dlac_pkg::OFS_LOW, 8'h01);
		master_run = 1'b1;
		phase(1'b1, 6);
		phase(1'b0, 3);
		master_run = 1'b0;
		wr(dlac_pkg::OFS_LOW, 8'h02);
		@(negedge clk);
		slave_hold = 1'b1;
		for (n = 0; n < 100 && slave_release !== 1'b1; n++) begin
			@(negedge clk);
			slave_hold = 1'b0;
		end
		chk("slave setup", n >= 5 && n <= 7, 1'b1);
		wrap_up();
	end
endmodule : testbench
